// ==== rtl/rivl_init_loader.sv ====
// Loads initial values into the CPU state and peripheral registers.
// Assumes one clock; pins are asynchronous, other inputs are on clk_sys.
//
// How it works
// - Reset loads counter zero, flag one, stack top
// - Interrupt enable, requests cleared; masks all set
// - High-voltage latches and direction control cleared
// - Medium latches set to ones
// - Function select A cleared
// - Function select B cleared on pin or watchdog reset
// - Function select C cleared
// - Counter A mode cleared
// - Counter B mode one cleared
// - Counter B mode two low bits cleared
// - Mode, shift, prescalers and counter values cleared
// - Counter B reload low nibble cleared only
// - Counter C reload low nibble cleared only
// - ADC modes, channel, step counter cleared; result mid
// - Slow clock and direct switch flags cleared
// - Watchdog, ADC start, bias off flags cleared
// - Capture status flag cleared
// - Capture error flag cleared
// - Clock select one bits two to zero cleared
// - Clock select two and extras register cleared
// - Stop release sets retained flag, keeps bit3s
// - Working registers are not held here

`timescale 1ns/10ps

module rivl_init_loader (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Reset and stop release pins, active low
   input wire logic reset_pin_n,
   input wire logic stop_release_pin_n,
   // Same-domain reset sources
   input wire logic wdog_overflow,
   input wire logic stop_mode,
   // Register write port and hardware request sets
   input wire rivl_pkg::rivl_wr_t wr,
   input wire logic [rivl_pkg::W_IRQ-1:0] irq_req_set,
   // Register bank and reset status
   output rivl_pkg::rivl_bank_t regs_q,
   output logic ram_retained_flag,
   output logic in_reset,
   output rivl_pkg::rivl_cause_t last_cause
);

   // -----------------------------------------
   // Declarations
   // -----------------------------------------
   // Synchronised pins {reset, stop release}
   logic [rivl_pkg::SYNC_W-1:0] pins_s;
   // Decoded causes
   logic pin_rst;
   logic stop_rel;
   logic hard_load;
   logic stop_load;
   logic load_now;
   // Write qualification
   logic wr_ok;
   logic [rivl_pkg::REG_W-1:0] wr_impl;
   logic [rivl_pkg::REG_W-1:0] req_base;
   // State
   rivl_pkg::rivl_bank_t regs_ff;
   rivl_pkg::rivl_phase_t phase_ff;
   rivl_pkg::rivl_phase_t nxt_phase;
   rivl_pkg::rivl_cause_t cause_ff;
   rivl_pkg::rivl_cause_t nxt_cause;
   logic ram_ret_ff;

   // -----------------------------------------
   // Pin synchroniser
   // -----------------------------------------
   rivl_sync #(
      .WIDTH(rivl_pkg::SYNC_W),
      .IDLE(2'b11)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d_async({reset_pin_n, stop_release_pin_n}),
      .q_sync(pins_s)
   );

   // -----------------------------------------
   // Cause decode
   // -----------------------------------------
   // Reset pin and watchdog win over stop release
   always_comb begin
      pin_rst = ~pins_s[1];
      stop_rel = ~pins_s[0] & stop_mode;
      hard_load = pin_rst | wdog_overflow;
      stop_load = stop_rel & ~hard_load;
      load_now = hard_load | stop_load;
      if (pin_rst) begin
         nxt_cause = rivl_pkg::CAUSE_PIN;
      end else if (wdog_overflow) begin
         nxt_cause = rivl_pkg::CAUSE_WDOG;
      end else if (stop_load) begin
         nxt_cause = rivl_pkg::CAUSE_STOP;
      end else begin
         nxt_cause = cause_ff;
      end
   end

   // Phase: reset state held while a cause stands
   always_comb begin
      case (phase_ff)
         rivl_pkg::PH_RUN: begin
            nxt_phase = load_now ? rivl_pkg::PH_HOLD : rivl_pkg::PH_RUN;
         end
         rivl_pkg::PH_HOLD: begin
            nxt_phase = load_now ? rivl_pkg::PH_HOLD : rivl_pkg::PH_RUN;
         end
         default: begin
            nxt_phase = rivl_pkg::PH_HOLD;
         end
      endcase
   end

   // Writes only outside the reset state and to mapped indices
   always_comb begin
      wr_ok = wr.en && !load_now && (phase_ff == rivl_pkg::PH_RUN)
              && (wr.idx < rivl_pkg::IDX_W'(rivl_pkg::NUM_REGS));
      wr_impl = rivl_pkg::rivl_info(rivl_pkg::rivl_reg_t'(wr.idx)).impl;
      // Software may only clear request flags
      req_base = regs_ff[rivl_pkg::REG_IRQ_REQ];
      if (wr_ok && (wr.idx == rivl_pkg::REG_IRQ_REQ)) begin
         req_base = req_base & wr.data;
      end
   end

   // -----------------------------------------
   // Phase and cause registers
   // -----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_ff <= rivl_pkg::PH_HOLD;
         cause_ff <= rivl_pkg::CAUSE_PIN;
      end else begin
         phase_ff <= nxt_phase;
         cause_ff <= nxt_cause;
      end
   end

   // -----------------------------------------
   // Retained flag
   // -----------------------------------------
   // stop release sets
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ram_ret_ff <= 1'b0;
      end else if (hard_load) begin
         ram_ret_ff <= 1'b0;
      end else if (stop_load) begin
         ram_ret_ff <= 1'b1;
      end
   end

   // -----------------------------------------
   // Register bank
   // -----------------------------------------
   // only table registers held
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // Full reset image, undefined bits forced to zero
         for (int i = 0; i < rivl_pkg::NUM_REGS; i++) begin
            regs_ff[i] <= rivl_pkg::rivl_info(rivl_pkg::rivl_reg_t'(i)).rst;
         end
      end else if (load_now) begin
         for (int i = 0; i < rivl_pkg::NUM_REGS; i++) begin
            automatic rivl_pkg::rivl_field_t f =
               rivl_pkg::rivl_info(rivl_pkg::rivl_reg_t'(i));
            automatic logic [rivl_pkg::REG_W-1:0] k = ~f.init;
            if (stop_load) begin
               k = k | f.keep;
            end
            regs_ff[i] <= ((regs_ff[i] & k) | (f.rst & ~k)) & f.impl;
         end
      end else begin
         if (wr_ok) begin
            regs_ff[wr.idx] <= wr.data & wr_impl;
         end
         // Hardware set wins over software clear
         regs_ff[rivl_pkg::REG_IRQ_REQ] <=
            (req_base | {9'h000, irq_req_set}) &
            rivl_pkg::rivl_info(rivl_pkg::REG_IRQ_REQ).impl;
      end
   end

   // -----------------------------------------
   // Outputs
   // -----------------------------------------
   assign regs_q = regs_ff;
   assign ram_retained_flag = ram_ret_ff;
   assign in_reset = (phase_ff == rivl_pkg::PH_HOLD);
   assign last_cause = cause_ff;

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   AST_CPU_STATE: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_PROG_CNT] == '0
         && regs_ff[rivl_pkg::REG_COND_FLAG] == rivl_pkg::RV_ONE
         && regs_ff[rivl_pkg::REG_STACK_PTR] == rivl_pkg::RV_STACK_TOP)
      else $error("CPU state not loaded");

   AST_IRQ_INIT: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_IRQ_EN] == '0
         && regs_ff[rivl_pkg::REG_IRQ_REQ] == '0
         && regs_ff[rivl_pkg::REG_IRQ_MASK] == 16'h007F)
      else $error("Interrupt bits not initialised");

   AST_HV_DIR: assert property (
      $fell(pins_s[1]) |=> regs_ff[rivl_pkg::REG_LATCH_HV] == '0
         && regs_ff[rivl_pkg::REG_DIR_CTRL] == '0)
      else $error("High-voltage latch or direction not clear");

   AST_MV_ONES: assert property (
      load_now ##1 !load_now |-> regs_ff[rivl_pkg::REG_LATCH_MV] == 16'h000F)
      else $error("Medium latch not all ones");

   AST_FUNC_A: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_FUNC_A] == '0)
      else $error("Function select A not clear");

   AST_FUNC_B: assert property (
      hard_load |=> regs_ff[rivl_pkg::REG_FUNC_B] == '0)
      else $error("Function select B not clear");

   AST_FUNC_C: assert property (
      load_now[*2] |-> regs_ff[rivl_pkg::REG_FUNC_C] == '0)
      else $error("Function select C not clear");

   AST_CNTA_MODE: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CNTA_MODE] == '0)
      else $error("Counter A mode not clear");

   AST_CNTB_MODE1: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CNTB_MODE1] == '0)
      else $error("Counter B mode one not clear");

   AST_CNTB_MODES: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CNTB_MODE1] == '0
         && regs_ff[rivl_pkg::REG_CNTB_MODE2] == '0)
      else $error("Counter B modes not clear");

   AST_COUNTERS: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_MAIN_PRE] == '0
         && regs_ff[rivl_pkg::REG_SUB_PRE] == '0
         && regs_ff[rivl_pkg::REG_CNTC_VAL] == '0
         && regs_ff[rivl_pkg::REG_SHIFT_MODE] == '0)
      else $error("Prescaler or counter not clear");

   AST_RELOAD_B: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CNTB_RELOAD][3:0] == '0
         && regs_ff[rivl_pkg::REG_CNTB_RELOAD][7:4]
            == $past(regs_ff[rivl_pkg::REG_CNTB_RELOAD][7:4]))
      else $error("Counter B reload nibbles wrong");

   AST_RELOAD_C: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CNTC_RELOAD][3:0] == '0
         && regs_ff[rivl_pkg::REG_CNTC_RELOAD][7:4]
            == $past(regs_ff[rivl_pkg::REG_CNTC_RELOAD][7:4]))
      else $error("Counter C reload nibbles wrong");

   AST_ADC_INIT: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_ADC_RESULT] == rivl_pkg::RV_ADC_MID
         && regs_ff[rivl_pkg::REG_EIGHT_STEP] == '0
         && regs_ff[rivl_pkg::REG_ADC_CHAN] == '0)
      else $error("ADC registers not initialised");

   AST_FLAGS: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_FLAG_BITS] == '0)
      else $error("Bit flags not clear");

   AST_SPEED_FLAGS: assert property (
      load_now |=> !regs_ff[rivl_pkg::REG_FLAG_BITS][rivl_pkg::FB_SLOW_CLK]
         && !regs_ff[rivl_pkg::REG_FLAG_BITS][rivl_pkg::FB_DIRECT])
      else $error("Speed flags not clear");

   AST_CAP_STAT: assert property (
      load_now |=> !regs_ff[rivl_pkg::REG_FLAG_BITS][rivl_pkg::FB_CAP_STAT])
      else $error("Capture status flag not clear");

   AST_CAP_ERR: assert property (
      load_now |=> !regs_ff[rivl_pkg::REG_FLAG_BITS][rivl_pkg::FB_CAP_ERR])
      else $error("Capture error flag not clear");

   AST_CLK_SEL: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CLK_SEL1][2:0] == '0
         && regs_ff[rivl_pkg::REG_CLK_SEL2] == '0)
      else $error("Clock select not clear");

   AST_CLK2_EXTRAS: assert property (
      load_now |=> regs_ff[rivl_pkg::REG_CLK_SEL2] == '0
         && regs_ff[rivl_pkg::REG_EXTRAS] == '0)
      else $error("Clock select two or extras not clear");

   AST_STOP_KEEP: assert property (
      stop_load |=> ram_ret_ff
         && regs_ff[rivl_pkg::REG_FUNC_B][3]
            == $past(regs_ff[rivl_pkg::REG_FUNC_B][3]))
      else $error("Stop release lost retained state");

   AST_HARD_CLEARS_RAM: assert property (
      hard_load |=> !ram_ret_ff && in_reset)
      else $error("Reset did not clear retained flag");

   AST_MISSING_BITS: assert property (
      (regs_ff[rivl_pkg::REG_CNTB_MODE2] & 16'hFFF8) == '0)
      else $error("Missing bits not constant");

   COV_PIN_RESET: cover property ($fell(pins_s[1]) ##[1:4] !load_now);
   COV_WDOG: cover property (wdog_overflow && !pin_rst);
   COV_STOP: cover property (stop_load ##1 !load_now);
   COV_WRITE: cover property (in_reset ##1 !in_reset ##[1:4] wr_ok);

endmodule

// ==== rtl/rivl_pkg.sv ====
// Package for the reset initial value loader.
// Assumes a single system clock and no register bus.

package rivl_pkg;

   // ----------------------------------------
   // Bank shape
   // ----------------------------------------
   localparam int unsigned REG_W = 16;
   localparam int unsigned NUM_REGS = 33;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned SYNC_W = 2;

   // Register bank indices
   typedef enum logic [IDX_W-1:0] {
      REG_PROG_CNT, REG_COND_FLAG, REG_STACK_PTR, REG_IRQ_EN,
      REG_IRQ_REQ, REG_IRQ_MASK, REG_LATCH_HV, REG_LATCH_MV,
      REG_DIR_CTRL, REG_FUNC_A, REG_FUNC_B, REG_FUNC_C,
      REG_CNTA_MODE, REG_CNTB_MODE1, REG_CNTB_MODE2, REG_CNTC_MODE,
      REG_SHIFT_MODE, REG_MAIN_PRE, REG_SUB_PRE, REG_CNTA_VAL,
      REG_CNTB_VAL, REG_CNTC_VAL, REG_CNTB_RELOAD, REG_CNTC_RELOAD,
      REG_EIGHT_STEP, REG_ADC_MODE1, REG_ADC_MODE2, REG_ADC_CHAN,
      REG_ADC_RESULT, REG_FLAG_BITS, REG_EXTRAS, REG_CLK_SEL1,
      REG_CLK_SEL2
   } rivl_reg_t;

   // ----------------------------------------
   // Implemented widths
   // ----------------------------------------
   localparam int unsigned W_PROG_CNT = 14;
   localparam int unsigned W_STACK_PTR = 10;
   localparam int unsigned W_BIT = 1;
   localparam int unsigned W_TWO = 2;
   localparam int unsigned W_TRI = 3;
   localparam int unsigned W_NIB = 4;
   localparam int unsigned W_IRQ = 7;
   localparam int unsigned W_BYTE = 8;
   localparam int unsigned W_MAIN_PRE = 12;

   // ----------------------------------------
   // Values after reset
   // ----------------------------------------
   localparam logic [REG_W-1:0] RV_ZERO = 16'h0000;
   localparam logic [REG_W-1:0] RV_ONE = 16'h0001;
   localparam logic [REG_W-1:0] RV_ONES = 16'hFFFF;
   localparam logic [REG_W-1:0] RV_STACK_TOP = 16'h03FF;
   localparam logic [REG_W-1:0] RV_ADC_MID = 16'h0080;
   localparam logic [REG_W-1:0] INIT_LOW_NIB = 16'h000F;
   localparam logic [REG_W-1:0] KEEP_BIT3 = 16'h0008;

   // Flag bit positions in the flag register
   localparam int unsigned FB_SLOW_CLK = 0;
   localparam int unsigned FB_DIRECT = 1;
   localparam int unsigned FB_WDOG_ON = 2;
   localparam int unsigned FB_ADC_START = 3;
   localparam int unsigned FB_CAP_STAT = 4;
   localparam int unsigned FB_CAP_ERR = 5;
   localparam int unsigned FB_ADC_BIAS = 6;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef logic [NUM_REGS-1:0][REG_W-1:0] rivl_bank_t;

   typedef struct packed {
      logic en;
      logic [IDX_W-1:0] idx;
      logic [REG_W-1:0] data;
   } rivl_wr_t;

   typedef struct packed {
      logic [REG_W-1:0] impl;
      logic [REG_W-1:0] init;
      logic [REG_W-1:0] keep;
      logic [REG_W-1:0] rst;
   } rivl_field_t;

   typedef enum logic [1:0] {
      CAUSE_NONE, CAUSE_PIN, CAUSE_WDOG, CAUSE_STOP
   } rivl_cause_t;

   typedef enum logic {PH_RUN, PH_HOLD} rivl_phase_t;

   // Mask of the low w bits
   function automatic logic [REG_W-1:0] rivl_ones(input int unsigned w);
      return REG_W'((32'h1 << w) - 32'h1);
   endfunction

   // Field built from width and reset value
   function automatic rivl_field_t rivl_mk(input int unsigned w,
                                           input logic [REG_W-1:0] v);
      rivl_field_t f;
      f.impl = rivl_ones(w);
      f.init = f.impl;
      f.keep = RV_ZERO;
      f.rst = v & f.impl;
      return f;
   endfunction

   // Layout and reset image of every register
   function automatic rivl_field_t rivl_info(input rivl_reg_t r);
      rivl_field_t f;
      f = rivl_mk(W_NIB, RV_ZERO);
      case (r)
         REG_PROG_CNT: f = rivl_mk(W_PROG_CNT, RV_ZERO);
         REG_COND_FLAG: f = rivl_mk(W_BIT, RV_ONE);
         REG_STACK_PTR: f = rivl_mk(W_STACK_PTR, RV_STACK_TOP);
         REG_IRQ_EN: f = rivl_mk(W_BIT, RV_ZERO);
         REG_IRQ_REQ: f = rivl_mk(W_IRQ, RV_ZERO);
         REG_IRQ_MASK: f = rivl_mk(W_IRQ, RV_ONES);
         REG_LATCH_MV: f = rivl_mk(W_NIB, RV_ONES);
         REG_CNTB_MODE2: f = rivl_mk(W_TRI, RV_ZERO);
         REG_MAIN_PRE: f = rivl_mk(W_MAIN_PRE, RV_ZERO);
         REG_SUB_PRE, REG_CNTA_VAL, REG_CNTB_VAL, REG_CNTC_VAL:
            f = rivl_mk(W_BYTE, RV_ZERO);
         REG_CNTB_RELOAD, REG_CNTC_RELOAD: begin
            f = rivl_mk(W_BYTE, RV_ZERO);
            f.init = INIT_LOW_NIB;
         end
         REG_EIGHT_STEP, REG_ADC_MODE2: f = rivl_mk(W_TRI, RV_ZERO);
         REG_ADC_RESULT: f = rivl_mk(W_BYTE, RV_ADC_MID);
         REG_FLAG_BITS: f = rivl_mk(W_IRQ, RV_ZERO);
         REG_FUNC_B, REG_CLK_SEL1: f.keep = KEEP_BIT3;
         REG_CLK_SEL2: f = rivl_mk(W_TWO, RV_ZERO);
         default: f = rivl_mk(W_NIB, RV_ZERO);
      endcase
      return f;
   endfunction

endpackage

// ==== rtl/rivl_sync.sv ====
// Two-stage synchroniser for pin levels.
// Assumes pins are asynchronous to clk_sys; the reset level is a constant.

`timescale 1ns/10ps

module rivl_sync #(
   parameter int unsigned WIDTH = 2,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pin side
   input wire logic [WIDTH-1:0] d_async,
   // Clock side
   output logic [WIDTH-1:0] q_sync
);

   // First stage, read only by the second stage
   logic [WIDTH-1:0] meta_ff;
   // Second stage
   logic [WIDTH-1:0] sync_ff;

   // --------------------------------
   // Two flip-flop chain
   // --------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_ff <= IDLE;
         sync_ff <= IDLE;
      end else begin
         meta_ff <= d_async;
         sync_ff <= meta_ff;
      end
   end

   assign q_sync = sync_ff;

endmodule

// ==== sim/test_reset_initial_value_loader.sv ====
// Testbench for the reset initial value loader.
// Assumes rivl_pkg is compiled first; drives every port from the bench.

`timescale 1ns/10ps

module test_reset_initial_value_loader;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_sys;
   logic rst_n;
   logic reset_pin_n;
   logic stop_release_pin_n;
   logic wdog_overflow;
   logic stop_mode;
   rivl_pkg::rivl_wr_t wr;
   logic [rivl_pkg::W_IRQ-1:0] irq_req_set;
   rivl_pkg::rivl_bank_t regs_q;
   logic ram_retained_flag;
   logic in_reset;
   rivl_pkg::rivl_cause_t last_cause;
   int n_errors;
   int checked;

   // Device under test
   rivl_init_loader dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .reset_pin_n(reset_pin_n),
      .stop_release_pin_n(stop_release_pin_n),
      .wdog_overflow(wdog_overflow),
      .stop_mode(stop_mode),
      .wr(wr),
      .irq_req_set(irq_req_set),
      .regs_q(regs_q),
      .ram_retained_flag(ram_retained_flag),
      .in_reset(in_reset),
      .last_cause(last_cause)
   );

   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Expected values
   // ----------------------------------------
   // Implemented bits of each register
   function automatic logic [15:0] impl_mask(input int i);
      case (i)
         0: return 16'h3fff;
         1, 3: return 16'h0001;
         2: return 16'h03ff;
         4, 5, 29: return 16'h007f;
         14, 24, 26: return 16'h0007;
         17: return 16'h0fff;
         18, 19, 20, 21, 22, 23, 28: return 16'h00ff;
         32: return 16'h0003;
         default: return 16'h000f;
      endcase
   endfunction

   // Image after a cause; upper is the kept reload nibble
   function automatic logic [15:0] exp_img(input int i,
                                           input logic [3:0] upper,
                                           input bit stop);
      case (i)
         1: return 16'h0001;
         2: return 16'h03ff;
         5: return 16'h007f;
         7: return 16'h000f;
         22, 23: return {8'h00, upper, 4'h0};
         28: return 16'h0080;
         10, 31: return stop ? 16'h0008 : 16'h0000;
         default: return 16'h0000;
      endcase
   endfunction

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Bounded wait for the reset state flag
   task automatic wait_reset(input logic val);
      int k;
      for (k = 0; k < 20 && in_reset !== val; k++) begin
         @(negedge clk_sys);
      end
      if (in_reset !== val) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time,
                  in_reset, val);
         finish_test();
      end
   endtask

   // One write cycle; a gap follows before the next one
   task automatic wr_reg(input int i, input logic [15:0] d);
      @(negedge clk_sys);
      wr.en = 1'b1;
      wr.idx = rivl_pkg::IDX_W'(i);
      wr.data = d;
      @(negedge clk_sys);
      wr.en = 1'b0;
   endtask

   // Whole bank against the reset image
   task automatic check_image(input logic [3:0] upper, input bit stop);
      for (int i = 0; i < 33; i++) begin
         check(regs_q[i], exp_img(i, upper, stop));
      end
   endtask

   // Write ones everywhere, then raise every request
   task automatic fill_ones();
      for (int i = 0; i < 33; i++) begin
         wr_reg(i, 16'hffff);
      end
      irq_req_set = 7'h7f;
      @(negedge clk_sys);
      irq_req_set = 7'h00;
      @(negedge clk_sys);
   endtask

   // Bank against implemented masks
   task automatic check_ones();
      for (int i = 0; i < 33; i++) begin
         check(regs_q[i], impl_mask(i));
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Image after the bench reset
   task automatic test_power_up();
      check_image(4'h0, 1'b0);
      check({15'h0000, ram_retained_flag}, 16'h0000);
      check({14'h0000, last_cause}, {14'h0000, rivl_pkg::CAUSE_PIN});
      $display("test power_up done");
   endtask

   // Masked writes and unmapped indices
   task automatic test_fill();
      fill_ones();
      check_ones();
      wr_reg(33, 16'h0000);
      wr_reg(63, 16'h0000);
      check_ones();
      $display("test fill done");
   endtask

   // Fill, apply one cause with a refused write, check image
   // Kind 3 pulls the reset pin during a stop release: the pin wins
   task automatic test_cause(input int kind);
      logic [1:0] cs;
      fill_ones();
      @(negedge clk_sys);
      if (kind == 0 || kind == 3) begin
         reset_pin_n = 1'b0;
      end
      if (kind == 1) begin
         wdog_overflow = 1'b1;
      end
      if (kind >= 2) begin
         stop_mode = 1'b1;
         stop_release_pin_n = 1'b0;
      end
      wait_reset(1'b1);
      // Write while the cause stands must be dropped
      wr_reg(9, 16'h0005);
      reset_pin_n = 1'b1;
      wdog_overflow = 1'b0;
      stop_mode = 1'b0;
      stop_release_pin_n = 1'b1;
      wait_reset(1'b0);
      check_image(4'hf, kind == 2);
      check({15'h0000, ram_retained_flag}, {15'h0000, kind == 2});
      cs = (kind == 1) ? rivl_pkg::CAUSE_WDOG :
           (kind == 2) ? rivl_pkg::CAUSE_STOP : rivl_pkg::CAUSE_PIN;
      check({14'h0000, last_cause}, {14'h0000, cs});
      $display("test cause %0d done", kind);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      n_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      reset_pin_n = 1'b1;
      stop_release_pin_n = 1'b1;
      wdog_overflow = 1'b0;
      stop_mode = 1'b0;
      wr = '0;
      irq_req_set = 7'h00;
      // Bench reset held six cycles
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      wait_reset(1'b0);
      test_power_up();
      test_fill();
      // Pin, watchdog, stop release, and pin during stop release
      for (int k = 0; k < 4; k++) begin
         test_cause(k);
      end
      finish_test();
   end

endmodule
